// [hw/flash_access_protection.sv]
// Access guard for program flash, data flash and ROM, with password unlock over APB
// Notes on behaviour
// - Program-flash program/erase allowed unprotected, else only with password key bit set.
// - Data-flash reads: any on-chip source unless mode B, then only flash-fetched instructions.
// - Data-flash access from outside the chip is always refused.
// - Data-flash program allowed unless mode B without the password key bit.
// - Mode A data-flash erase needs prior unlock bit or password key bit.
// - Protection removed only in boot-loader mode by a matching password.
// - Password match erases protected flash contents and the stored password.
// - Hardware mode change applies at next reset; other settings apply at once.
// - With ROM read-out protection, ROM reads only from instructions running in ROM.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fap_defs.svh"
module flash_access_protection (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Stored configuration, sampled after reset release
    input  wire fap_pkg::fap_mode_t  stored_mode,
    input  wire logic [7:0]          stored_pwd,
    // Boot-loader mode pin
    input  wire logic                boot_loader,
    // CPU request
    input  wire logic                req_valid,
    input  wire fap_pkg::fap_kind_t  req_kind,
    input  wire fap_pkg::fap_tgt_t   req_target,
    input  wire fap_pkg::fap_src_t   req_src,
    input  wire logic [15:0]         req_addr,
    input  wire logic [7:0]          req_wdata,
    output logic                     req_ready,
    output logic                     req_grant,
    output logic                     req_deny,
    output logic [7:0]               cpu_rdata,
    // Flash array port
    input  wire logic [7:0]          flash_rdata,
    output logic                     flash_cmd_valid,
    output fap_pkg::fap_kind_t       flash_cmd_kind,
    output fap_pkg::fap_tgt_t        flash_cmd_target,
    output logic [15:0]              flash_cmd_addr,
    output logic [7:0]               flash_cmd_wdata,
    output logic                     erase_req,
    output logic [3:0]               erase_sector,
    input  wire logic                erase_ack,
    // Mode to store for the next reset
    output fap_pkg::fap_mode_t       next_mode,
    output logic                     next_mode_valid
);
    // Access decision used by the grant and deny logic
    function automatic logic fap_allow(fap_pkg::fap_mode_t m, fap_pkg::fap_kind_t k,
                                       fap_pkg::fap_tgt_t t, fap_pkg::fap_src_t s,
                                       logic key, logic unl, logic romp);
        logic ok;
        ok = 1'b0;
        if (s == fap_pkg::src_ext && t == fap_pkg::fap_dflash)
            ok = 1'b0;
        else if (t == fap_pkg::fap_pflash)
            ok = (k == fap_pkg::fap_read) || m == fap_pkg::fap_unprot || key;
        else if (t == fap_pkg::fap_rom)
            ok = (k == fap_pkg::fap_read) && (!romp || s == fap_pkg::src_rom);
        else if (k == fap_pkg::fap_read)
            ok = m != fap_pkg::fap_prot_b || s == fap_pkg::src_pflash
                 || s == fap_pkg::src_dflash;
        else if (k == fap_pkg::fap_program)
            ok = m != fap_pkg::fap_prot_b || key;
        else
            ok = m == fap_pkg::fap_unprot || key
                 || (m == fap_pkg::fap_prot_a && unl);
        return ok;
    endfunction : fap_allow

    logic               bl_meta_q;
    logic               bl_sync_q;
    logic               cap_q;
    fap_pkg::fap_mode_t mode_q;
    fap_pkg::fap_mode_t mode_d;
    logic [7:0]         pwd_q;
    logic [7:0]         pwd_d;
    logic               unlock_q;
    logic               unlock_d;
    logic               romprot_q;
    logic               romprot_d;
    logic               match_q;
    logic               match_d;
    logic               fail_q;
    logic               fail_d;
    fap_pkg::fap_mode_t pend_q;
    fap_pkg::fap_mode_t pend_d;
    logic               pend_vld_q;
    logic               pend_vld_d;
    logic [31:0]        prdata_q;
    logic [31:0]        prdata_d;
    logic               cmd_vld_q;
    logic [7:0]         rdata_q;
    logic [7:0]         rdata_d;
    logic               seq_busy;
    logic               wr_acc;
    logic               pwd_wr;
    logic               pwd_hit;
    logic               allowed;
    logic               df_erase_go;

    // Boot-loader pin comes from outside: two flip-flops before use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bl_meta_q <= 1'b0;
            bl_sync_q <= 1'b0;
        end
        else
        begin
            bl_meta_q <= boot_loader;
            bl_sync_q <= bl_meta_q;
        end
    end

    // Decoding of bus writes and CPU requests
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && paddr > `FAP_OFF_PEND;
    assign wr_acc      = psel && penable && pwrite;
    assign pwd_wr      = wr_acc && paddr == `FAP_OFF_PASSWORD && bl_sync_q && cap_q
                         && !seq_busy;
    assign pwd_hit     = pwd_wr && pwdata[7:0] == pwd_q;
    assign req_ready   = cap_q && !seq_busy;
    assign allowed     = fap_allow(mode_q, req_kind, req_target, req_src,
                                   pwd_q[`FAP_PWD_KEY_BIT], unlock_q, romprot_q);
    assign req_grant   = req_valid && req_ready && allowed;
    assign req_deny    = req_valid && req_ready && !allowed;
    assign df_erase_go = req_grant && req_target == fap_pkg::fap_dflash
                         && req_kind == fap_pkg::fap_erase;

    // Next values of the control state
    always_comb
    begin
        mode_d     = mode_q;
        pwd_d      = pwd_q;
        unlock_d   = unlock_q;
        romprot_d  = romprot_q;
        match_d    = match_q;
        fail_d     = fail_q;
        pend_d     = pend_q;
        pend_vld_d = pend_vld_q;
        rdata_d    = rdata_q;
        prdata_d   = prdata_q;
        if (!cap_q)
        begin
            // Stored mode is frozen until the next reset
            mode_d = stored_mode;
            pwd_d  = stored_pwd;
        end
        // Unlock is consumed by each mode A data-flash erase; a write in the same cycle wins
        if (df_erase_go && mode_q == fap_pkg::fap_prot_a)
            unlock_d = 1'b0;
        if (wr_acc && paddr == `FAP_OFF_CTRL)
        begin
            unlock_d  = pwdata[`FAP_CTRL_UNLOCK];
            romprot_d = pwdata[`FAP_CTRL_ROMPROT];
        end
        if (pwd_hit)
        begin
            pwd_d   = 8'h00;
            match_d = 1'b1;
            fail_d  = 1'b0;
        end
        else if (pwd_wr)
            fail_d = 1'b1;
        // New hardware mode only after a valid password, stored for reset
        if (wr_acc && paddr == `FAP_OFF_PEND && match_q
            && pwdata[1:0] <= 2'h2)
        begin
            pend_d     = fap_pkg::fap_mode_t'(pwdata[1:0]);
            pend_vld_d = 1'b1;
        end
        if (req_grant && req_kind == fap_pkg::fap_read)
            rdata_d = flash_rdata;
        else if (req_deny)
            rdata_d = 8'h00;
        if (psel && !penable)
        begin
            case (paddr)
                `FAP_OFF_CTRL:
                    prdata_d = {30'h0, romprot_q, unlock_q};
                `FAP_OFF_STATUS:
                    prdata_d = {21'h0, pend_vld_q, pend_q, fail_q, match_q, seq_busy,
                                romprot_q, unlock_q, pwd_q[`FAP_PWD_KEY_BIT], mode_q};
                `FAP_OFF_PEND:
                    prdata_d = {30'h0, pend_q};
                default:
                    prdata_d = 32'h0;
            endcase
        end
    end

    // Control state registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_q      <= 1'b0;
            mode_q     <= fap_pkg::fap_prot_b;  // Strictest until sampled
            pwd_q      <= 8'h00;
            unlock_q   <= 1'b0;
            romprot_q  <= 1'b0;
            match_q    <= 1'b0;
            fail_q     <= 1'b0;
            pend_q     <= fap_pkg::fap_unprot;
            pend_vld_q <= 1'b0;
            rdata_q    <= 8'h00;
            prdata_q   <= 32'h0;
            cmd_vld_q  <= 1'b0;
            flash_cmd_kind   <= fap_pkg::fap_read;
            flash_cmd_target <= fap_pkg::fap_pflash;
            flash_cmd_addr   <= 16'h0000;
            flash_cmd_wdata  <= 8'h00;
        end
        else
        begin
            cap_q      <= 1'b1;
            mode_q     <= mode_d;
            pwd_q      <= pwd_d;
            unlock_q   <= unlock_d;
            romprot_q  <= romprot_d;
            match_q    <= match_d;
            fail_q     <= fail_d;
            pend_q     <= pend_d;
            pend_vld_q <= pend_vld_d;
            rdata_q    <= rdata_d;
            prdata_q   <= prdata_d;
            cmd_vld_q  <= req_grant;
            if (req_grant)
            begin
                flash_cmd_kind   <= req_kind;
                flash_cmd_target <= req_target;
                flash_cmd_addr   <= req_addr;
                flash_cmd_wdata  <= req_wdata;
            end
        end
    end

    // Bulk erase after a password match
    fap_erase_seq u_erase (
        .pclk         (pclk),
        .presetn      (presetn),
        .start        (pwd_hit),
        .busy         (seq_busy),
        .erase_req    (erase_req),
        .erase_sector (erase_sector),
        .erase_ack    (erase_ack)
    );

    assign prdata          = prdata_q;
    assign cpu_rdata       = rdata_q;
    assign flash_cmd_valid = cmd_vld_q;
    assign next_mode       = pend_q;
    assign next_mode_valid = pend_vld_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pf_guard;
        req_valid && req_ready && req_target == fap_pkg::fap_pflash
        && req_kind != fap_pkg::fap_read && mode_q != fap_pkg::fap_unprot
        && !pwd_q[6] |-> req_deny ##1 !flash_cmd_valid;
    endproperty
    a_pf_guard: assert property (p_pf_guard) else $error("pflash write not refused");

    property p_df_read;
        req_valid && req_ready && req_target == fap_pkg::fap_dflash
        && req_kind == fap_pkg::fap_read && mode_q == fap_pkg::fap_prot_b
        && req_src inside {fap_pkg::src_rom, fap_pkg::src_ram} |=> cpu_rdata == 8'h00;
    endproperty
    a_df_read: assert property (p_df_read) else $error("dflash read leaked");

    property p_ext;
        req_valid && req_src == fap_pkg::src_ext
        && req_target == fap_pkg::fap_dflash |-> !req_grant;
    endproperty
    a_ext: assert property (p_ext) else $error("external dflash access granted");

    property p_df_prog;
        req_valid && req_ready && req_target == fap_pkg::fap_dflash
        && req_kind == fap_pkg::fap_program && mode_q != fap_pkg::fap_prot_b
        && req_src != fap_pkg::src_ext |-> req_grant ##1 flash_cmd_valid;
    endproperty
    a_df_prog: assert property (p_df_prog) else $error("dflash program refused");

    property p_unlock_used;
        df_erase_go && mode_q == fap_pkg::fap_prot_a
        && !(wr_acc && paddr == `FAP_OFF_CTRL) |=> !unlock_q;
    endproperty
    a_unlock_used: assert property (p_unlock_used) else $error("unlock not consumed");

    property p_pwd_kept;
        wr_acc && paddr == `FAP_OFF_PASSWORD && !bl_sync_q |=> $stable(pwd_q) && !seq_busy;
    endproperty
    a_pwd_kept: assert property (p_pwd_kept) else $error("password outside boot mode");

    sequence s_hit;
        pwd_hit;
    endsequence
    sequence s_wipe;
        pwd_q == 8'h00 && seq_busy ##1 erase_req;
    endsequence
    property p_wipe;
        s_hit |=> s_wipe;
    endproperty
    a_wipe: assert property (p_wipe) else $error("match did not erase");

    property p_mode_frozen;
        cap_q |=> $stable(mode_q);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed without reset");

    property p_rom;
        req_valid && romprot_q && req_target == fap_pkg::fap_rom
        && req_src != fap_pkg::src_rom |-> !req_grant;
    endproperty
    a_rom: assert property (p_rom) else $error("ROM read-out not blocked");

    property p_deny_quiet;
        req_deny |=> !flash_cmd_valid && cpu_rdata == 8'h00;
    endproperty
    a_deny_quiet: assert property (p_deny_quiet) else $error("denied request reached flash");
endmodule : flash_access_protection

// [hw/fap_defs.svh]
// Register offsets, field positions, reset values and counts of the flash access guard
`ifndef FAP_DEFS_SVH
`define FAP_DEFS_SVH
`define FAP_OFF_CTRL        8'h00
`define FAP_OFF_STATUS      8'h04
`define FAP_OFF_PASSWORD    8'h08
`define FAP_OFF_PEND        8'h0C
`define FAP_CTRL_UNLOCK     0
`define FAP_CTRL_ROMPROT    1
`define FAP_CTRL_RESET      2'h0
`define FAP_PWD_W           8
`define FAP_PWD_KEY_BIT     6
`define FAP_ST_MODE_LO      0
`define FAP_ST_PWDBIT       2
`define FAP_ST_UNLOCK       3
`define FAP_ST_ROMPROT      4
`define FAP_ST_BUSY         5
`define FAP_ST_MATCH        6
`define FAP_ST_FAIL         7
`define FAP_ST_PEND_LO      8
`define FAP_ST_PEND_VLD     10
`define FAP_ERASE_SECTORS   5'h10
`endif

// [hw/fap_pkg.sv]
// Types shared by the flash access guard and its erase sequencer
package fap_pkg;
    typedef enum logic [1:0] {fap_unprot, fap_prot_a, fap_prot_b} fap_mode_t;
    typedef enum logic [1:0] {fap_read, fap_program, fap_erase} fap_kind_t;
    typedef enum logic [1:0] {fap_pflash, fap_dflash, fap_rom} fap_tgt_t;
    typedef enum logic [2:0] {src_pflash, src_dflash, src_rom, src_ram, src_ext} fap_src_t;
    typedef enum logic [1:0] {seq_idle, seq_issue, seq_wait} fap_seq_t;
endpackage : fap_pkg

// [hw/fap_erase_seq.sv]
// Bulk erase sequencer walking every protected sector after a password match
`timescale 1ns/1ps
`include "fap_defs.svh"
module fap_erase_seq (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       start,
    output logic            busy,
    // Flash erase port
    output logic            erase_req,
    output logic [3:0]      erase_sector,
    input  wire logic       erase_ack
);
    fap_pkg::fap_seq_t state_q;
    fap_pkg::fap_seq_t state_d;
    logic [4:0]        sec_q;
    logic [4:0]        sec_d;

    // Next state: one sector per request, acknowledged by the flash
    always_comb
    begin
        state_d = state_q;
        sec_d   = sec_q;
        case (state_q)
            fap_pkg::seq_idle:
                if (start)
                begin
                    state_d = fap_pkg::seq_issue;
                    sec_d   = 5'h00;
                end
            fap_pkg::seq_issue:
                if (erase_ack)
                begin
                    sec_d   = sec_q + 5'h01;
                    state_d = (sec_q + 5'h01 == `FAP_ERASE_SECTORS) ? fap_pkg::seq_idle
                                                                    : fap_pkg::seq_wait;
                end
            fap_pkg::seq_wait:
                state_d = fap_pkg::seq_issue;   // One idle cycle between sectors
            default:
                state_d = fap_pkg::seq_idle;
        endcase
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= fap_pkg::seq_idle;
            sec_q   <= 5'h00;
        end
        else
        begin
            state_q <= state_d;
            sec_q   <= sec_d;
        end
    end

    assign busy         = (state_q != fap_pkg::seq_idle);
    assign erase_req    = (state_q == fap_pkg::seq_issue);
    assign erase_sector = sec_q[3:0];
endmodule : fap_erase_seq

// [sim/fap_flash_model.sv]
// Flash array model facing the access guard's command and bulk erase ports
`timescale 1ns/1ps
module fap_flash_model (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Read port
    input  wire logic [15:0]        req_addr,
    output logic [7:0]              flash_rdata,
    // Command port
    input  wire logic               flash_cmd_valid,
    input  wire fap_pkg::fap_kind_t flash_cmd_kind,
    input  wire logic [15:0]        flash_cmd_addr,
    input  wire logic [7:0]         flash_cmd_wdata,
    // Bulk erase port
    input  wire logic               erase_req,
    input  wire logic [3:0]         erase_sector,
    output logic                    erase_ack
);
    logic [7:0] mem_q [256];
    logic [1:0] wait_q;

    // Known start pattern, so the bench predicts every byte
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem_q[i] = 8'(i) ^ 8'hA5;
    end

    // Array answers combinationally for the request address
    assign flash_rdata = mem_q[req_addr[7:0]];

    // Commands and bulk erase; odd sectors answered slowly to stretch the handshake
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            erase_ack <= 1'b0;
            wait_q    <= 2'h0;
        end
        else
        begin
            erase_ack <= 1'b0;
            if (flash_cmd_valid && flash_cmd_kind == fap_pkg::fap_program)
                mem_q[flash_cmd_addr[7:0]] <= flash_cmd_wdata;
            if (flash_cmd_valid && flash_cmd_kind == fap_pkg::fap_erase)
                mem_q[flash_cmd_addr[7:0]] <= 8'hFF;
            if (erase_req && !erase_ack)
            begin
                if (wait_q == {erase_sector[0], erase_sector[0]})
                begin
                    erase_ack <= 1'b1;
                    wait_q    <= 2'h0;
                    for (int i = 0; i < 16; i++)
                        mem_q[{erase_sector, i[3:0]}] <= 8'hFF;
                end
                else
                    wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule : fap_flash_model

// [sim/flash_access_protection_bench.sv]
// Self-checking bench for the flash access guard
`timescale 1ns/1ps
`include "fap_defs.svh"
module flash_access_protection_bench;
    typedef fap_pkg::fap_mode_t fap_mode_t;
    typedef fap_pkg::fap_kind_t fap_kind_t;
    typedef fap_pkg::fap_tgt_t  fap_tgt_t;
    typedef fap_pkg::fap_src_t  fap_src_t;
    // Local aliases of the package labels, so scenario lines stay short
    localparam fap_mode_t fap_unprot = fap_pkg::fap_unprot, fap_prot_a = fap_pkg::fap_prot_a,
                          fap_prot_b = fap_pkg::fap_prot_b;
    localparam fap_kind_t fap_read = fap_pkg::fap_read, fap_program = fap_pkg::fap_program,
                          fap_erase = fap_pkg::fap_erase;
    localparam fap_tgt_t  fap_pflash = fap_pkg::fap_pflash, fap_dflash = fap_pkg::fap_dflash,
                          fap_rom = fap_pkg::fap_rom;
    localparam fap_src_t  src_pflash = fap_pkg::src_pflash, src_dflash = fap_pkg::src_dflash,
                          src_rom = fap_pkg::src_rom, src_ram = fap_pkg::src_ram,
                          src_ext = fap_pkg::src_ext;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]         paddr, stored_pwd, req_wdata, cpu_rdata, flash_rdata, flash_cmd_wdata;
    logic [31:0]        pwdata, prdata, rd;
    fap_mode_t          stored_mode, next_mode;
    fap_kind_t          req_kind, flash_cmd_kind;
    fap_tgt_t           req_target, flash_cmd_target;
    fap_src_t           req_src;
    logic               boot_loader, req_valid, req_ready, req_grant, req_deny;
    logic               flash_cmd_valid, erase_req, erase_ack, next_mode_valid;
    logic [15:0]        req_addr, flash_cmd_addr;
    logic [3:0]         erase_sector;
    int                 fail_count, n_compared, cyc;

    flash_access_protection u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .stored_mode, .stored_pwd, .boot_loader, .req_valid, .req_kind,
        .req_target, .req_src, .req_addr, .req_wdata, .req_ready, .req_grant, .req_deny,
        .cpu_rdata, .flash_rdata, .flash_cmd_valid, .flash_cmd_kind, .flash_cmd_target,
        .flash_cmd_addr, .flash_cmd_wdata, .erase_req, .erase_sector, .erase_ack,
        .next_mode, .next_mode_valid);
    fap_flash_model u_flash (
        .pclk, .presetn, .req_addr, .flash_rdata, .flash_cmd_valid, .flash_cmd_kind,
        .flash_cmd_addr, .flash_cmd_wdata, .erase_req, .erase_sector, .erase_ack);

    // Clock, start values and a hang guard
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, boot_loader, req_valid} = '0;
        {paddr, pwdata, stored_pwd, req_addr, req_wdata} = '0;
        stored_mode = fap_unprot;
        req_kind    = fap_read;
        req_target  = fap_pflash;
        req_src     = src_pflash;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] pat(input logic [7:0] a);
        return a ^ 8'hA5;
    endfunction : pat

    task automatic rst(input fap_mode_t m, input logic [7:0] p);
        @(posedge pclk);
        presetn <= 1'b0;
        stored_mode <= m;
        stored_pwd <= p;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : rst

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One CPU request; d is write data, or expected read data
    task automatic rq(input fap_kind_t k, input fap_tgt_t t, input fap_src_t s,
                      input logic [7:0] a, input logic [7:0] d, input logic g);
        do
        begin
            @(negedge pclk);
        end
        while (req_ready !== 1'b1);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_target <= t;
        req_src <= s;
        req_addr <= {8'h00, a};
        req_wdata <= d;
        @(negedge pclk);
        chk(req_grant, g, "grant");
        chk(req_deny, !g, "deny");
        @(posedge pclk);
        req_valid <= 1'b0;
        @(negedge pclk);
        chk(flash_cmd_valid, g, "flash command");
        if (g)
            chk({flash_cmd_kind, flash_cmd_target, flash_cmd_addr}, {k, t, 8'h00, a},
                "command fields");
        if (k == fap_read || !g)
            chk(cpu_rdata, g ? d : 8'h00, "cpu data");
    endtask : rq

    task automatic wait_erase(input logic lvl);
        do
        begin
            @(negedge pclk);
        end
        while (erase_req !== lvl);
    endtask : wait_erase

    task automatic t_regs();
        rst(fap_unprot, 8'h00);
        apb(0, `FAP_OFF_CTRL, 0);
        chk(rd, 0, "ctrl reset");
        apb(1, `FAP_OFF_CTRL, 32'h3);
        apb(0, `FAP_OFF_CTRL, 0);
        chk(rd, 32'h3, "ctrl rw");
        apb(1, `FAP_OFF_CTRL, 0);
        apb(0, `FAP_OFF_PASSWORD, 0);
        chk(rd, 0, "password reads zero");
        apb(0, 8'h10, 0);
        chk(err, 1, "unmapped error");
        chk(rd, 0, "unmapped data");
    endtask : t_regs

    task automatic t_unprot();
        rq(fap_program, fap_pflash, src_ram, 8'h40, 8'h12, 1);
        rq(fap_read, fap_dflash, src_ram, 8'h41, pat(8'h41), 1);
        rq(fap_read, fap_dflash, src_ext, 8'h41, 8'h00, 0);
        rq(fap_program, fap_dflash, src_ext, 8'h42, 8'h66, 0);
        rq(fap_program, fap_dflash, src_pflash, 8'h43, 8'h34, 1);
        rq(fap_read, fap_dflash, src_pflash, 8'h43, 8'h34, 1);
    endtask : t_unprot

    task automatic t_mode_a();
        rst(fap_prot_a, 8'h00);
        rq(fap_program, fap_pflash, src_pflash, 8'h20, 8'h55, 0);
        rq(fap_erase, fap_pflash, src_pflash, 8'h21, 8'h00, 0);
        rq(fap_read, fap_pflash, src_pflash, 8'h20, pat(8'h20), 1);
        rq(fap_read, fap_dflash, src_ram, 8'h22, pat(8'h22), 1);
        rq(fap_erase, fap_dflash, src_pflash, 8'h23, 8'h00, 0);
        apb(1, `FAP_OFF_CTRL, 32'h1);
        rq(fap_erase, fap_dflash, src_pflash, 8'h23, 8'h00, 1);
        rq(fap_erase, fap_dflash, src_pflash, 8'h24, 8'h00, 0);
        rq(fap_read, fap_dflash, src_pflash, 8'h23, 8'hFF, 1);
        rq(fap_program, fap_dflash, src_pflash, 8'h25, 8'h3C, 1);
        rst(fap_prot_a, 8'h40);
        rq(fap_program, fap_pflash, src_pflash, 8'h26, 8'h77, 1);
        rq(fap_erase, fap_dflash, src_pflash, 8'h27, 8'h00, 1);
    endtask : t_mode_a

    task automatic t_mode_b();
        rst(fap_prot_b, 8'h00);
        rq(fap_read, fap_dflash, src_ram, 8'h28, 8'h00, 0);
        rq(fap_read, fap_dflash, src_rom, 8'h28, 8'h00, 0);
        rq(fap_read, fap_dflash, src_dflash, 8'h28, pat(8'h28), 1);
        rq(fap_program, fap_dflash, src_dflash, 8'h29, 8'h11, 0);
        rq(fap_erase, fap_pflash, src_pflash, 8'h29, 8'h00, 0);
        rq(fap_read, fap_dflash, src_ext, 8'h28, 8'h00, 0);
        rq(fap_read, fap_dflash, src_dflash, 8'h29, pat(8'h29), 1);
        rst(fap_prot_b, 8'h40);
        rq(fap_program, fap_dflash, src_pflash, 8'h29, 8'h11, 1);
    endtask : t_mode_b

    task automatic t_rom();
        rst(fap_unprot, 8'h00);
        rq(fap_read, fap_rom, src_ram, 8'h30, pat(8'h30), 1);
        apb(1, `FAP_OFF_CTRL, 32'h2);
        rq(fap_read, fap_rom, src_ram, 8'h30, 8'h00, 0);
        rq(fap_read, fap_rom, src_rom, 8'h30, pat(8'h30), 1);
    endtask : t_rom

    // Password removal, bulk erase and deferred mode change
    task automatic t_pwd();
        rst(fap_prot_b, 8'h5A);
        apb(1, `FAP_OFF_PASSWORD, 32'h5A);
        apb(0, `FAP_OFF_STATUS, 0);
        chk(rd[`FAP_ST_MATCH], 0, "match without boot loader");
        boot_loader <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1, `FAP_OFF_PASSWORD, 32'h11);
        apb(0, `FAP_OFF_STATUS, 0);
        chk(rd[7:6], 2'b10, "wrong password");
        apb(1, `FAP_OFF_PASSWORD, 32'h5A);
        for (int s = 0; s < 16; s++)
        begin
            wait_erase(1'b1);
            chk(erase_sector, s, "sector order");
            wait_erase(1'b0);
        end
        apb(0, `FAP_OFF_STATUS, 0);
        chk(rd[`FAP_ST_MATCH], 1, "match");
        chk(rd[`FAP_ST_PWDBIT], 0, "password erased");
        apb(1, `FAP_OFF_PEND, 32'h0);
        apb(0, `FAP_OFF_STATUS, 0);
        chk(rd[1:0], fap_prot_b, "mode before reset");
        chk({next_mode_valid, next_mode}, 3'b100, "pending mode");
        boot_loader <= 1'b0;
        rst(next_mode, 8'h00);
        apb(0, `FAP_OFF_STATUS, 0);
        chk(rd[1:0], fap_unprot, "mode after reset");
        rq(fap_read, fap_pflash, src_pflash, 8'h50, 8'hFF, 1);
    endtask : t_pwd

    // Main sequence
    initial
    begin
        t_regs();
        t_unprot();
        t_mode_a();
        t_mode_b();
        t_rom();
        t_pwd();
        end_sim();
    end
endmodule : flash_access_protection_bench
